/* hw/fci_host.sv */
// Host controller that issues command sequences to a byte-wide flash through its pins.
`timescale 1ns/1ps
`include "fci_regs.svh"
module fci_host import fci_pkg::*; #(
  parameter int ADDR_W = 20
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic req_valid,
  output logic req_ready,
  input wire fci_op_type req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [7:0] req_data,
  input wire logic program_voltage_high,
  output logic resp_valid,
  output logic resp_refused,
  output logic [7:0] resp_data,
  output logic mode_array,
  input wire logic ready_busy_n,
  output logic powerdown_reset_n,
  input wire logic powerdown_req,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in,
  output logic flash_select_n,
  output logic flash_output_n,
  output logic flash_strobe_n
);
  // Two-write operations go through a second phase; step marks it.
  logic step;
  logic active;
  fci_op_type op;
  logic [ADDR_W-1:0] addr;
  logic [7:0] data;
  logic cyc_start;
  logic cyc_write;
  logic [ADDR_W-1:0] cyc_addr;
  logic [7:0] cyc_data;
  logic cyc_busy;
  logic cyc_done;
  logic [7:0] cyc_rdata;
  logic refuse;
  logic two_write;

  function automatic logic needs_vpp(input fci_op_type o);
    return (o == FCI_OP_ERASE) || (o == FCI_OP_WRITE_BYTE) || (o == FCI_OP_RESUME) || (o == FCI_OP_SUSPEND);
  endfunction : needs_vpp

  function automatic logic [7:0] first_code(input fci_op_type o, input logic [7:0] d);
    case (o)
      FCI_OP_READ_ARRAY: return `FCI_CMD_READ_ARRAY; // [RQ4]
      FCI_OP_IDENT: return `FCI_CMD_IDENT; // [RQ8]
      FCI_OP_READ_STATUS: return `FCI_CMD_READ_STATUS; // [RQ10]
      FCI_OP_CLEAR_STATUS: return `FCI_CMD_CLEAR_STATUS; // [RQ10]
      FCI_OP_ERASE: return `FCI_CMD_ERASE_SETUP; // [RQ11]
      FCI_OP_SUSPEND: return `FCI_CMD_SUSPEND; // [RQ12]
      FCI_OP_RESUME: return `FCI_CMD_CONFIRM; // [RQ12]
      FCI_OP_WRITE_BYTE: return `FCI_CMD_WRITE_SETUP; // [RQ13]
      default: return d;
    endcase
  endfunction : first_code

  assign two_write = (op == FCI_OP_ERASE) || (op == FCI_OP_WRITE_BYTE);
  // Erase, byte write, suspend and resume are refused without high voltage; array read while busy is refused too.
  assign refuse = (needs_vpp(req_op) && !program_voltage_high) // [RQ15] [RQ9] [RQ16]
    || (req_op == FCI_OP_READ_ARRAY && !ready_busy_n) // [RQ7] [RQ18]
    || (req_op > FCI_OP_READ); // [RQ17]
  assign req_ready = !active && !cyc_busy && !cyc_start && powerdown_reset_n;
  assign cyc_write = (op != FCI_OP_READ);
  assign cyc_addr = addr; // Command codes go out at the caller's address; no fixed command address. [RQ3]
  assign cyc_data = step ? data : first_code(op, data); // [RQ14]

  always_ff @(posedge clock) begin
    if (rst) begin
      powerdown_reset_n <= 1'b0;
    end else if (clock_enable) begin
      powerdown_reset_n <= !powerdown_req; // Low aborts erase or write inside the device. [RQ20] [RQ21]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      active <= 1'b0;
      step <= 1'b0;
      op <= FCI_OP_READ_ARRAY;
      addr <= '0;
      data <= 8'h00;
      cyc_start <= 1'b0;
      resp_valid <= 1'b0;
      resp_refused <= 1'b0;
      resp_data <= 8'h00;
    end else if (clock_enable) begin
      cyc_start <= 1'b0;
      resp_valid <= 1'b0;
      resp_refused <= 1'b0;
      if (req_valid && req_ready) begin
        if (refuse) begin
          resp_valid <= 1'b1;
          resp_refused <= 1'b1;
        end else begin
          active <= 1'b1;
          step <= 1'b0;
          op <= req_op;
          addr <= req_addr;
          data <= req_data;
          cyc_start <= 1'b1;
        end
      end else if (active && cyc_done) begin
        if (two_write && !step) begin
          step <= 1'b1;
          if (op == FCI_OP_ERASE) begin
            data <= `FCI_CMD_CONFIRM; // Confirm uses the same block address. [RQ11]
          end
          cyc_start <= 1'b1;
        end else begin
          active <= 1'b0;
          step <= 1'b0;
          resp_valid <= 1'b1;
          resp_data <= cyc_rdata;
        end
      end
    end
  end

  // Tracks the read mode the device holds after each command. [RQ6]
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_array <= 1'b1;
    end else if (clock_enable) begin
      if (!powerdown_reset_n) begin
        mode_array <= 1'b1; // [RQ5] [RQ19]
      end else if (active && cyc_done && op != FCI_OP_READ) begin
        mode_array <= (op == FCI_OP_READ_ARRAY);
      end
    end
  end

  fci_cycle #(.ADDR_W(ADDR_W)) u_cycle (
    .clock(clock),
    .rst(rst),
    .enable(clock_enable),
    .start(cyc_start),
    .is_write(cyc_write),
    .addr(cyc_addr),
    .wdata(cyc_data),
    .busy(cyc_busy),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in),
    .flash_select_n(flash_select_n),
    .flash_output_n(flash_output_n),
    .flash_strobe_n(flash_strobe_n)
  );

  // Gating checks: a refused request must never reach the pins, or the device could start an operation.
  a_refuse_erase: assert property (@(posedge clock) disable iff (rst) // [RQ15]
    (clock_enable && req_valid && req_ready && req_op == FCI_OP_ERASE && !program_voltage_high)
    |=> resp_valid && resp_refused) else $error("erase sent without high voltage");
  a_vpp_write: assert property (@(posedge clock) disable iff (rst) // [RQ15]
    (clock_enable && req_valid && req_ready && req_op == FCI_OP_WRITE_BYTE && !program_voltage_high)
    |=> resp_valid && resp_refused) else $error("byte write sent without high voltage");
  a_refused_quiet: assert property (@(posedge clock) disable iff (rst) // [RQ15]
    (clock_enable && req_valid && req_ready && refuse) |=> !cyc_start && !active)
    else $error("refused request reached the pins");
  a_refuse_flag: assert property (@(posedge clock) disable iff (rst) // [RQ15]
    resp_refused |-> resp_valid) else $error("refusal without response");
  a_refuse_array: assert property (@(posedge clock) disable iff (rst) // [RQ7]
    (clock_enable && req_valid && req_ready && req_op == FCI_OP_READ_ARRAY && !ready_busy_n)
    |=> resp_refused) else $error("array read sent while busy");
  a_array_accepted: assert property (@(posedge clock) disable iff (rst) // [RQ16]
    (clock_enable && req_valid && req_ready && req_op == FCI_OP_READ_ARRAY && ready_busy_n)
    |=> cyc_start) else $error("array read refused while ready");
  a_ident_ok: assert property (@(posedge clock) disable iff (rst) // [RQ9]
    (clock_enable && req_valid && req_ready && req_op == FCI_OP_IDENT)
    |=> cyc_start && !resp_refused) else $error("identifier refused");

  // Code checks: each operation must put its own command byte, and a byte write its payload, on the data pins while the strobe is low.
  a_erase_confirm: assert property (@(posedge clock) disable iff (rst) // [RQ11]
    (active && op == FCI_OP_ERASE && step && !flash_strobe_n) |-> flash_dq_out == `FCI_CMD_CONFIRM)
    else $error("erase confirm code wrong");
  a_setup_code: assert property (@(posedge clock) disable iff (rst) // [RQ13]
    (active && op == FCI_OP_WRITE_BYTE && !step && !flash_strobe_n) |-> flash_dq_out == `FCI_CMD_WRITE_SETUP)
    else $error("write setup code wrong");
  a_write_payload: assert property (@(posedge clock) disable iff (rst) // [RQ14]
    (active && op == FCI_OP_WRITE_BYTE && step && !flash_strobe_n) |-> flash_dq_out == data)
    else $error("write payload byte wrong");
  a_array_code: assert property (@(posedge clock) disable iff (rst) // [RQ4]
    (active && op == FCI_OP_READ_ARRAY && !flash_strobe_n) |-> flash_dq_out == `FCI_CMD_READ_ARRAY)
    else $error("array read code wrong");
  a_ident_code: assert property (@(posedge clock) disable iff (rst) // [RQ8]
    (active && op == FCI_OP_IDENT && !flash_strobe_n) |-> flash_dq_out == `FCI_CMD_IDENT)
    else $error("identifier code wrong");
  a_status_code: assert property (@(posedge clock) disable iff (rst) // [RQ10]
    (active && op == FCI_OP_READ_STATUS && !flash_strobe_n) |-> flash_dq_out == `FCI_CMD_READ_STATUS)
    else $error("status read code wrong");
  a_clear_code: assert property (@(posedge clock) disable iff (rst) // [RQ10]
    (active && op == FCI_OP_CLEAR_STATUS && !flash_strobe_n) |-> flash_dq_out == `FCI_CMD_CLEAR_STATUS)
    else $error("status clear code wrong");
  a_suspend_code: assert property (@(posedge clock) disable iff (rst) // [RQ12]
    (active && op == FCI_OP_SUSPEND && !flash_strobe_n) |-> flash_dq_out == `FCI_CMD_SUSPEND)
    else $error("suspend code wrong");
  a_resume_code: assert property (@(posedge clock) disable iff (rst) // [RQ12]
    (active && op == FCI_OP_RESUME && !flash_strobe_n) |-> flash_dq_out == `FCI_CMD_CONFIRM)
    else $error("resume code wrong");

  // Address checks: a pair that drifts to another block would erase or program the wrong place.
  a_pair_addr: assert property (@(posedge clock) disable iff (rst) // [RQ11]
    (active && two_write && !flash_strobe_n) |-> flash_addr == addr)
    else $error("pair address moved");
  a_read_addr: assert property (@(posedge clock) disable iff (rst) // [RQ8]
    (active && op == FCI_OP_READ && !flash_output_n) |-> flash_addr == addr)
    else $error("read address moved");

  // Mode and power-down checks.
  a_mode_persist: assert property (@(posedge clock) disable iff (rst) // [RQ6]
    (clock_enable && !(active && cyc_done) && powerdown_reset_n) |=> $stable(mode_array))
    else $error("read mode changed without command");
  a_pd_array: assert property (@(posedge clock) disable iff (rst) // [RQ19]
    (clock_enable && !powerdown_reset_n) |=> mode_array) else $error("mode not array after power-down");
  a_pd_follow: assert property (@(posedge clock) disable iff (rst) // [RQ20]
    (clock_enable && powerdown_req) |=> !powerdown_reset_n) else $error("power-down request not passed on");
endmodule : fci_host

/* hw/fci_regs.svh */
// Command codes, identifier addresses and bus cycle timing for the flash command host.
// Notes on behaviour
// (RQ1) Write: strobe low with select low.
// (RQ2) Device latches address, data on strobe rise.
// (RQ3) Commands use no memory address; one latch.
// (RQ4) FFH write selects array read.
// (RQ5) Array read after power-up or power-down exit.
// (RQ6) Read mode persists until next command.
// (RQ7) Array-read command ignored while machine busy.
// (RQ8) 90H then read 0/1 gives identifier codes.
// (RQ9) Identifier reads need no high voltage.
// (RQ10) 70H selects status read; 50H clears status.
// (RQ11) Erase is 20H then D0H in block.
// (RQ12) B0H suspends erase; D0H resumes.
// (RQ13) 40H or 10H is byte-write setup.
// (RQ14) Next cycle gives byte and target address.
// (RQ15) Erase, write only with high programming voltage.
// (RQ16) Array-read works at either voltage.
// (RQ17) Host writes only defined command codes.
// (RQ18) Ready/busy low while erase or write runs.
// (RQ19) Power-down exit: array read, status 10000.
// (RQ20) Power-down low aborts erase or write.
// (RQ21) Decoder resets while power-down pin low.
`ifndef FCI_REGS_SVH
`define FCI_REGS_SVH
`define FCI_CMD_READ_ARRAY 8'hFF
`define FCI_CMD_IDENT 8'h90
`define FCI_CMD_READ_STATUS 8'h70
`define FCI_CMD_CLEAR_STATUS 8'h50
`define FCI_CMD_ERASE_SETUP 8'h20
`define FCI_CMD_CONFIRM 8'hD0
`define FCI_CMD_SUSPEND 8'hB0
`define FCI_CMD_WRITE_SETUP 8'h40
`define FCI_CMD_WRITE_SETUP_ALT 8'h10
`define FCI_ADDR_MAKER 20'h0_0000
`define FCI_ADDR_PART 20'h0_0001
`define FCI_STROBE_LOW_NS 100
`define FCI_STROBE_HIGH_NS 50
`define FCI_READ_ACCESS_NS 100
`define FCI_CLOCK_NS 10
`define FCI_STROBE_LOW_CYC ((`FCI_STROBE_LOW_NS + `FCI_CLOCK_NS - 1) / `FCI_CLOCK_NS)
`define FCI_STROBE_HIGH_CYC ((`FCI_STROBE_HIGH_NS + `FCI_CLOCK_NS - 1) / `FCI_CLOCK_NS)
`define FCI_READ_ACCESS_CYC ((`FCI_READ_ACCESS_NS + `FCI_CLOCK_NS - 1) / `FCI_CLOCK_NS)
`endif

/* hw/fci_pkg.sv */
// Types shared by the flash command host.
package fci_pkg;
  typedef enum logic [3:0] {
    FCI_OP_READ_ARRAY = 4'h0,
    FCI_OP_IDENT = 4'h1,
    FCI_OP_READ_STATUS = 4'h2,
    FCI_OP_CLEAR_STATUS = 4'h3,
    FCI_OP_ERASE = 4'h4,
    FCI_OP_SUSPEND = 4'h5,
    FCI_OP_RESUME = 4'h6,
    FCI_OP_WRITE_BYTE = 4'h7,
    FCI_OP_READ = 4'h8
  } fci_op_type;
  typedef enum logic [4:0] {
    FCI_IDLE = 5'b00001,
    FCI_LOW = 5'b00010,
    FCI_HIGH = 5'b00100,
    FCI_RLOW = 5'b01000,
    FCI_DONE = 5'b10000
  } fci_state_type;
endpackage : fci_pkg

/* hw/fci_cycle.sv */
// One bus cycle on the flash pins: a strobed write or a timed read.
`timescale 1ns/1ps
`include "fci_regs.svh"
module fci_cycle import fci_pkg::*; #(
  parameter int ADDR_W = 20
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic start,
  input wire logic is_write,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in,
  output logic flash_select_n,
  output logic flash_output_n,
  output logic flash_strobe_n
);
  localparam logic [3:0] LOW_CYC = 4'(`FCI_STROBE_LOW_CYC);
  localparam logic [3:0] HIGH_CYC = 4'(`FCI_STROBE_HIGH_CYC);
  localparam logic [3:0] ACC_CYC = 4'(`FCI_READ_ACCESS_CYC);
  fci_state_type state;
  logic [3:0] count;
  assign busy = (state != FCI_IDLE);
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= FCI_IDLE;
      count <= 4'h0;
      done <= 1'b0;
    end else if (enable) begin
      done <= 1'b0;
      case (state)
        FCI_IDLE: begin
          count <= 4'h0;
          if (start) begin
            state <= is_write ? FCI_LOW : FCI_RLOW;
          end
        end
        FCI_LOW: begin
          count <= count + 4'h1;
          if (count == LOW_CYC - 4'h1) begin
            count <= 4'h0;
            state <= FCI_HIGH; // Device latches on this rising strobe. [RQ2]
          end
        end
        FCI_RLOW: begin
          count <= count + 4'h1;
          if (count == ACC_CYC - 4'h1) begin
            count <= 4'h0;
            state <= FCI_HIGH;
          end
        end
        FCI_HIGH: begin
          count <= count + 4'h1;
          if (count == HIGH_CYC - 4'h1) begin
            state <= FCI_DONE;
          end
        end
        FCI_DONE: begin
          done <= 1'b1;
          state <= FCI_IDLE;
        end
        default: state <= FCI_IDLE;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      flash_addr <= '0;
      flash_dq_out <= 8'h00;
      flash_dq_oe <= 1'b0;
      flash_select_n <= 1'b1;
      flash_output_n <= 1'b1;
      flash_strobe_n <= 1'b1;
      rdata <= 8'h00;
    end else if (enable) begin
      if (state == FCI_IDLE && start) begin
        flash_addr <= addr;
        flash_dq_out <= wdata;
        flash_dq_oe <= is_write;
        flash_select_n <= 1'b0;
        flash_strobe_n <= ~is_write; // Strobe low only with select low. [RQ1]
        flash_output_n <= is_write;
      end else if ((state == FCI_LOW || state == FCI_RLOW) && count == ((state == FCI_LOW) ? LOW_CYC : ACC_CYC) - 4'h1) begin
        if (state == FCI_RLOW) begin
          rdata <= flash_dq_in;
        end
        flash_strobe_n <= 1'b1;
        flash_output_n <= 1'b1;
      end else if (state == FCI_DONE) begin
        flash_select_n <= 1'b1;
        flash_dq_oe <= 1'b0;
      end
    end
  end
  a_strobe_select: assert property (@(posedge clock) disable iff (rst) // [RQ1]
    !flash_strobe_n |-> !flash_select_n) else $error("strobe low without select");
  a_data_held: assert property (@(posedge clock) disable iff (rst) // [RQ2]
    (!flash_strobe_n && enable) ##1 flash_strobe_n |-> $stable(flash_dq_out) && flash_dq_oe)
    else $error("write data not held at strobe rise");
endmodule : fci_cycle

/* verif/fci_flash_model.sv */
// Behavioural byte-wide flash device answering the host's pin cycles.
`timescale 1ns/1ps
module fci_flash_model #(
  parameter int BUSY_CYC = 80,
  parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value.
  parameter logic [7:0] PART_CODE = 8'hC3 // Arbitrary value.
) (
  input wire logic clock,
  input wire logic vpp_high,
  input wire logic [19:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_select_n,
  input wire logic flash_output_n,
  input wire logic flash_strobe_n,
  input wire logic powerdown_reset_n,
  output logic [7:0] flash_dq_in,
  output logic ready_busy_n
);
  logic [7:0] mem [int];
  int mode = 0;
  int busy = 0;
  logic susp = 1'b0;
  logic [7:0] pend = 8'h00;
  logic [7:0] cmd;
  assign ready_busy_n = busy == 0 || susp || !powerdown_reset_n;
  always @(negedge powerdown_reset_n) begin
    mode = 0;
    busy = 0;
    susp = 1'b0;
    pend = 8'h00;
  end
  always @(posedge clock) begin
    if (busy > 0 && !susp) begin
      busy = busy - 1;
    end
  end
  // A single latch keeps the pending setup code; commands occupy no array location.
  always @(posedge flash_strobe_n) begin
    if (!flash_select_n && powerdown_reset_n) begin
      cmd = pend;
      pend = 8'h00;
      if (cmd == 8'h20 && flash_dq_out == 8'hD0 && vpp_high) begin
        for (int i = 0; i < 65536; i++) mem.delete({flash_addr[19:16], i[15:0]});
        busy = BUSY_CYC;
      end else if (cmd == 8'h40 || cmd == 8'h10) begin
        if (vpp_high) begin
          mem[flash_addr] = flash_dq_out;
          busy = BUSY_CYC;
        end
      end else begin
        case (flash_dq_out)
          8'hFF: if (busy == 0) mode = 0;
          8'h90: mode = 1;
          8'h70: mode = 2;
          8'h20, 8'h40, 8'h10: begin
            pend = flash_dq_out;
            mode = 2;
          end
          8'hB0: susp = busy > 0;
          8'hD0: susp = 1'b0;
          default: ;
        endcase
      end
    end
  end
  always @* begin
    if (!flash_select_n && !flash_output_n && powerdown_reset_n) begin
      case (mode)
        0: flash_dq_in = mem.exists(flash_addr) ? mem[flash_addr] : 8'hFF;
        1: flash_dq_in = flash_addr[0] ? PART_CODE : MAKER_CODE;
        default: flash_dq_in = {ready_busy_n, susp, 6'h00};
      endcase
    end else begin
      // Released bus toggles between 5A and A5; 5A equals the maker code, so a late sample can look valid.
      flash_dq_in = 8'h5A ^ {8{clock}};
    end
  end
endmodule : fci_flash_model

/* verif/flash_command_interface_test.sv */
// Self-checking bench for the flash command host against a behavioural device.
`timescale 1ns/1ps
module flash_command_interface_test;
  import fci_pkg::*;
  localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value.
  localparam logic [7:0] PART = 8'hC3; // Arbitrary value.
  logic clock = 1'b0, rst = 1'b1, req_valid = 1'b0, vpp = 1'b0, powerdown_req = 1'b0, ce = 1'b1;
  fci_op_type req_op = FCI_OP_READ;
  logic [19:0] req_addr = 20'h0_0000, faddr, a;
  logic [7:0] req_data = 8'h00, resp_data, dq_out, dq_in, got, d;
  logic req_ready, resp_valid, resp_refused, mode_array, ready_busy_n, pd_n, dq_oe, sel_n, out_n, stb_n, got_ref;
  logic [7:0] emem [int];
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  initial begin
    forever #5 clock = ~clock;
  end
  fci_host DUT (.clock(clock), .rst(rst), .clock_enable(ce), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_addr(req_addr), .req_data(req_data), .program_voltage_high(vpp),
    .resp_valid(resp_valid), .resp_refused(resp_refused), .resp_data(resp_data), .mode_array(mode_array),
    .ready_busy_n(ready_busy_n), .powerdown_reset_n(pd_n), .powerdown_req(powerdown_req), .flash_addr(faddr),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in), .flash_select_n(sel_n),
    .flash_output_n(out_n), .flash_strobe_n(stb_n));
  fci_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) flash (.clock(clock), .vpp_high(vpp),
    .flash_addr(faddr), .flash_dq_out(dq_out), .flash_select_n(sel_n), .flash_output_n(out_n),
    .flash_strobe_n(stb_n), .powerdown_reset_n(pd_n), .flash_dq_in(dq_in), .ready_busy_n(ready_busy_n));
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp8
  task automatic cmp1(input logic g, input logic e);
    cmp8({7'h00, g}, {7'h00, e});
  endtask : cmp1
  function automatic logic [7:0] eread(input logic [19:0] ad);
    return emem.exists(ad) ? emem[ad] : 8'hFF;
  endfunction : eread
  task automatic run(input fci_op_type o, input logic [19:0] ad, input logic [7:0] dt);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 300) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 300) begin
      err_total++;
    end
    req_op = o;
    req_addr = ad;
    req_data = dt;
    req_valid = 1'b1;
    @(posedge clock);
    #1;
    req_valid = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && n < 300) begin
      @(posedge clock);
      #1;
      n++;
    end
    got_ref = resp_refused;
    got = resp_data;
    if (n >= 300) begin
      err_total++;
    end
    // One idle edge keeps back-to-back requests from toggling req_valid within one time step.
    @(posedge clock);
    #1;
  endtask : run
  task automatic rd_chk(input logic [19:0] ad, input logic [7:0] e);
    run(FCI_OP_READ, ad, 8'h00);
    cmp8(got, e);
  endtask : rd_chk
  task automatic wait_rb();
    int n;
    n = 0;
    while (ready_busy_n !== 1'b1 && n < 500) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 500) begin
      err_total++;
    end
  endtask : wait_rb
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(15229));
    repeat (2) @(posedge clock);
    #1;
    rst = 1'b0;
    cmp1(mode_array, 1'b1);
    a = 20'($urandom);
    d = 8'($urandom);
    rd_chk(a, eread(a));
    $display("test power-up read done");
    run(FCI_OP_IDENT, a, 8'h00);
    cmp1(mode_array, 1'b0);
    rd_chk(20'h0_0001, PART);
    rd_chk(20'h0_0000, MAKER);
    run(FCI_OP_READ_STATUS, a, 8'h00);
    rd_chk(~a, 8'h80);
    run(FCI_OP_CLEAR_STATUS, a, 8'h00);
    cmp1(got_ref, 1'b0);
    run(FCI_OP_ERASE, a, 8'h00);
    cmp1(got_ref, 1'b1);
    run(fci_op_type'(4'hF), a, 8'h00);
    cmp1(got_ref, 1'b1);
    $display("test read modes done");
    vpp = 1'b1;
    run(FCI_OP_WRITE_BYTE, a, d);
    emem[a] = d;
    cmp1(ready_busy_n, 1'b0);
    run(FCI_OP_READ_ARRAY, a, 8'h00);
    cmp1(got_ref, 1'b1);
    wait_rb();
    vpp = 1'b0;
    run(FCI_OP_READ_ARRAY, a, 8'h00);
    cmp1(got_ref, 1'b0);
    cmp1(mode_array, 1'b1);
    rd_chk(a, eread(a));
    $display("test byte write done");
    vpp = 1'b1;
    run(FCI_OP_ERASE, a, 8'h00);
    run(FCI_OP_SUSPEND, a, 8'h00);
    cmp1(ready_busy_n, 1'b1);
    run(FCI_OP_RESUME, a, 8'h00);
    cmp1(ready_busy_n, 1'b0);
    wait_rb();
    // Only one byte of the block was ever written, so dropping it empties the block.
    emem.delete(a);
    run(FCI_OP_READ_ARRAY, a, 8'h00);
    rd_chk(a, eread(a));
    $display("test erase done");
    run(FCI_OP_WRITE_BYTE, a ^ 20'h0_0001, d);
    // With the clock enable low the power-down request must not reach the pin yet.
    ce = 1'b0;
    powerdown_req = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    cmp1(pd_n, 1'b1);
    ce = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    cmp1(pd_n, 1'b0);
    cmp1(ready_busy_n, 1'b1);
    cmp1(mode_array, 1'b1);
    powerdown_req = 1'b0;
    rd_chk(a, eread(a));
    run(FCI_OP_READ_STATUS, a, 8'h00);
    rd_chk(a, 8'h80);
    $display("test power-down done");
    end_of_test();
  end
endmodule : flash_command_interface_test
